// ===== core/vdi_slave_port.sv
// device end: write-only two-wire slave of the video decoder
// Function
// - slave only, never starts, stops or clocks
// - strap picks write address b8 or ba
// - strap pin later drives video bit 7
// - bit rate at most 400 kbit/s
// - data changes only while clock low
// - falling data, clock high: start
// - rising data, clock high: stop
// - eight-bit bytes, unlimited byte count
// - ninth bit is receiver acknowledge
// - master sends address, write bit zero
// - subaddress byte, then data bytes
// - device acknowledges every accepted byte
// - master ends write with stop
// - idle bus has both lines released
// - hold clock low after low-register writes
`timescale 1ns/1ps
`default_nettype none
module vdi_slave_port (
  // link clock domain
  input  wire logic                      link_clk,
  input  wire logic                      rst,
  vdi_link_if.dev                        lnk,
  // shared strap and video bit pin
  input  wire logic                      video_output_bit7_pin_i,
  output logic                           video_output_bit7_pin_o,
  output logic                           video_output_bit7_pin_oe,
  input  wire logic                      video_bit7_data,
  // register write port
  output logic                           wr_valid,
  output logic [vdi_pkg::BYTE_W-1:0]     wr_addr,
  output logic [vdi_pkg::BYTE_W-1:0]     wr_data,
  // strap state
  output logic                           slave_address_select_strap,
  output logic                           strap_done
);
  import vdi_pkg::*;

  // synchroniser stages: scl, sda, strap pin
  logic [2:0]            sync1_ff;
  logic [2:0]            sync2_ff;
  logic [1:0]            prev_ff;
  logic                  scl_hi;
  logic                  sda_hi;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_seen;
  logic                  stop_seen;

  // receive state
  vdi_slv_st_type        st_ff;
  vdi_slv_st_type        nxt_st;
  vdi_kind_type          kind_ff;
  vdi_kind_type          nxt_kind;
  logic [3:0]            cnt_ff;
  logic [3:0]            nxt_cnt;
  logic [BYTE_W-1:0]     shift_ff;
  logic [BYTE_W-1:0]     nxt_shift;
  logic [BYTE_W-1:0]     ptr_ff;
  logic [BYTE_W-1:0]     nxt_ptr;
  logic [WAIT_W-1:0]     wait_ff;
  logic [WAIT_W-1:0]     nxt_wait;
  logic                  sda_oe_ff;
  logic                  nxt_sda_oe;
  logic                  scl_oe_ff;
  logic                  nxt_scl_oe;
  logic                  wr_vld_ff;
  logic                  nxt_wr_vld;
  logic [BYTE_W-1:0]     wr_addr_ff;
  logic [BYTE_W-1:0]     nxt_wr_addr;
  logic [BYTE_W-1:0]     wr_data_ff;
  logic [BYTE_W-1:0]     nxt_wr_data;

  // strap capture state
  logic [1:0]            strap_cnt_ff;
  logic [1:0]            nxt_strap_cnt;
  logic                  strap_ff;
  logic                  nxt_strap;
  logic                  strap_done_ff;
  logic                  nxt_strap_done;
  logic                  vid_o_ff;
  logic                  nxt_vid_o;

  // address this device answers
  function automatic logic [BYTE_W-1:0] own_addr(input logic sel);
    own_addr = sel ? WR_ADDR_HI : WR_ADDR_LO;
  endfunction

  // two flip-flops before any logic, third for edge history
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
      prev_ff  <= 2'h3;
    end else begin
      sync1_ff <= {video_output_bit7_pin_i, lnk.sda, lnk.scl};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff[1:0];
    end
  end

  // line events seen through the synchroniser
  assign scl_hi     = sync2_ff[0];
  assign sda_hi     = sync2_ff[1];
  assign scl_rise   = scl_hi && !prev_ff[0];
  assign scl_fall   = !scl_hi && prev_ff[0];
  assign start_seen = scl_hi && prev_ff[0] && prev_ff[1] && !sda_hi;
  assign stop_seen  = scl_hi && prev_ff[0] && !prev_ff[1] && sda_hi;

  // strap capture once after reset, then the pin turns output
  always_comb begin
    nxt_strap_cnt  = strap_cnt_ff;
    nxt_strap      = strap_ff;
    nxt_strap_done = strap_done_ff;
    // copy runs always, so the first driven cycle already carries data
    nxt_vid_o      = video_bit7_data;
    if (!strap_done_ff) begin
      nxt_strap_cnt = strap_cnt_ff + STRAP_ONE;
      if (strap_cnt_ff == STRAP_LAST) begin
        nxt_strap      = sync2_ff[2];
        nxt_strap_done = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      strap_cnt_ff  <= 2'h0;
      strap_ff      <= 1'b0;
      strap_done_ff <= 1'b0;
      vid_o_ff      <= 1'b0;
    end else begin
      strap_cnt_ff  <= nxt_strap_cnt;
      strap_ff      <= nxt_strap;
      strap_done_ff <= nxt_strap_done;
      vid_o_ff      <= nxt_vid_o;
    end
  end

  // byte receive, acknowledge and clock hold
  always_comb begin
    nxt_st      = st_ff;
    nxt_kind    = kind_ff;
    nxt_cnt     = cnt_ff;
    nxt_shift   = shift_ff;
    nxt_ptr     = ptr_ff;
    nxt_wait    = wait_ff;
    nxt_sda_oe  = sda_oe_ff;
    nxt_scl_oe  = scl_oe_ff;
    nxt_wr_vld  = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    if (!strap_done_ff) begin
      nxt_st = S_IDLE;
    end else if (start_seen) begin
      nxt_st     = S_RX;
      nxt_kind   = K_ADDR;
      nxt_cnt    = 4'h0;
      nxt_sda_oe = 1'b0;
    end else if (stop_seen) begin
      nxt_st     = S_IDLE;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
    end else begin
      case (st_ff)
        S_IDLE: begin
          nxt_sda_oe = 1'b0;
          nxt_scl_oe = 1'b0;
        end
        S_RX: begin
          if (scl_rise && cnt_ff != BIT_FULL) begin
            nxt_shift = {shift_ff[BYTE_W-2:0], sda_hi};
            nxt_cnt   = cnt_ff + BIT_ONE;
          end else if (scl_fall && cnt_ff == BIT_FULL) begin
            nxt_cnt = 4'h0;
            case (kind_ff)
              K_ADDR: begin
                if (shift_ff == own_addr(strap_ff)) begin
                  nxt_sda_oe = 1'b1;
                  nxt_st     = S_ACK;
                end else begin
                  nxt_st = S_IGNORE;
                end
              end
              K_SUB: begin
                nxt_ptr    = shift_ff;
                nxt_sda_oe = 1'b1;
                nxt_st     = S_ACK;
              end
              default: begin
                // register write leaves with the byte
                nxt_wr_vld  = 1'b1;
                nxt_wr_addr = ptr_ff;
                nxt_wr_data = shift_ff;
                nxt_sda_oe  = 1'b1;
                nxt_st      = S_ACK;
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            nxt_st     = S_RX;
            case (kind_ff)
              K_ADDR: nxt_kind = K_SUB;
              K_SUB: nxt_kind = K_DATA;
              default: begin
                nxt_ptr = ptr_ff + PTR_STEP;
                if (ptr_ff < NO_WAIT_BASE) begin
                  nxt_scl_oe = 1'b1;
                  nxt_wait   = '0;
                  nxt_st     = S_WAIT;
                end
              end
            endcase
          end
        end
        S_WAIT: begin
          nxt_wait = wait_ff + WAIT_ONE;
          if (wait_ff == WAIT_LAST) begin
            nxt_scl_oe = 1'b0;
            nxt_st     = S_RX;
          end
        end
        S_IGNORE: begin
          nxt_sda_oe = 1'b0;
        end
        default: begin
          nxt_st = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      st_ff      <= S_IDLE;
      kind_ff    <= K_ADDR;
      cnt_ff     <= 4'h0;
      shift_ff   <= 8'h00;
      ptr_ff     <= 8'h00;
      wait_ff    <= '0;
      sda_oe_ff  <= 1'b0;
      scl_oe_ff  <= 1'b0;
      wr_vld_ff  <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end else begin
      st_ff      <= nxt_st;
      kind_ff    <= nxt_kind;
      cnt_ff     <= nxt_cnt;
      shift_ff   <= nxt_shift;
      ptr_ff     <= nxt_ptr;
      wait_ff    <= nxt_wait;
      sda_oe_ff  <= nxt_sda_oe;
      scl_oe_ff  <= nxt_scl_oe;
      wr_vld_ff  <= nxt_wr_vld;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
    end
  end

  assign lnk.scl_dev_o  = 1'b0;
  assign lnk.scl_dev_oe = scl_oe_ff;
  // data driven from scl fall only
  assign lnk.sda_dev_o  = 1'b0;
  assign lnk.sda_dev_oe = sda_oe_ff;

  // pin is strap input, then video
  assign video_output_bit7_pin_o    = vid_o_ff;
  assign video_output_bit7_pin_oe   = strap_done_ff;
  assign wr_valid                   = wr_vld_ff;
  assign wr_addr                    = wr_addr_ff;
  assign wr_data                    = wr_data_ff;
  assign slave_address_select_strap = strap_ff;
  assign strap_done                 = strap_done_ff;
endmodule
`default_nettype wire

// ===== core/vdi_pkg.sv
// shared constants and types for the two-wire host control port
package vdi_pkg;

  // address bytes for the write direction, chosen by the strap
  localparam logic [7:0] WR_ADDR_LO   = 8'hb8;
  localparam logic [7:0] WR_ADDR_HI   = 8'hba;
  // first register that needs no processing wait
  localparam logic [7:0] NO_WAIT_BASE = 8'h90;
  localparam logic [7:0] PTR_STEP     = 8'h01;

  // byte framing
  localparam int         BYTE_W   = 8;
  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [3:0] BIT_ACK  = 4'h9;
  localparam logic [3:0] BIT_ONE  = 4'h1;

  // link clock and processing wait, longest time rounds down
  localparam int LNK_CLK_NS  = 64;
  localparam int STRETCH_NS  = 64000;
  localparam int STRETCH_CYC = (STRETCH_NS / LNK_CLK_NS < 1) ? 1 : STRETCH_NS / LNK_CLK_NS;
  localparam int WAIT_W      = 10;
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(STRETCH_CYC - 1);
  localparam logic [WAIT_W-1:0] WAIT_ONE  = 10'h001;

  // strap settle cycles after reset release
  localparam logic [1:0] STRAP_LAST = 2'h3;
  localparam logic [1:0] STRAP_ONE  = 2'h1;

  // host bit timing: 400 kbit/s, quarter bit, least time rounds up
  localparam int REF_CLK_PS = 4000;
  localparam int BIT_PS     = 2500000;
  localparam int QTR_CYC    = (BIT_PS / 4 + REF_CLK_PS - 1) / REF_CLK_PS;
  localparam int QTR_W      = 8;
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
  localparam logic [QTR_W-1:0] QTR_ONE  = 8'h01;

  // device receive states
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_RX     = 3'b001,
    S_ACK    = 3'b010,
    S_WAIT   = 3'b011,
    S_IGNORE = 3'b100
  } vdi_slv_st_type;

  // which byte of a write is on the wire
  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_SUB  = 2'b01,
    K_DATA = 2'b10
  } vdi_kind_type;

  // host states
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_START = 2'b01,
    M_XFER  = 2'b10,
    M_STOP  = 2'b11
  } vdi_mst_st_type;

endpackage

// ===== core/vdi_link_if.sv
// open-drain two-wire link joining host and device ends
`timescale 1ns/1ps
`default_nettype none
interface vdi_link_if;
  logic scl_dev_o;
  logic scl_dev_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl_hst_o;
  logic scl_hst_oe;
  logic sda_hst_o;
  logic sda_hst_oe;
  wire  scl;
  wire  sda;

  // wired-and: a line is low when any driver pulls it
  assign scl = !((scl_dev_oe && !scl_dev_o) || (scl_hst_oe && !scl_hst_o));
  assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_hst_oe && !sda_hst_o));

  modport dev (output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe, input scl, sda);
  modport host (output scl_hst_o, scl_hst_oe, sda_hst_o, sda_hst_oe, input scl, sda);
endinterface
`default_nettype wire

// ===== core/vdi_host_master.sv
// host end: two-wire write master that makes the link clock
`timescale 1ns/1ps
`default_nettype none
module vdi_host_master (
  // system clock domain
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  vdi_link_if.host                     lnk,
  // write request
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire logic [6:0]              req_addr7,
  input  wire logic [vdi_pkg::BYTE_W-1:0] req_sub,
  // data stream
  input  wire logic                    dat_valid,
  output logic                         dat_ready,
  input  wire logic [vdi_pkg::BYTE_W-1:0] dat_data,
  input  wire logic                    dat_last,
  // completion
  output logic                         done,
  output logic                         nack
);
  import vdi_pkg::*;

  logic [1:0]        sync1_ff;
  logic [1:0]        sync2_ff;
  vdi_mst_st_type    st_ff;
  vdi_mst_st_type    nxt_st;
  vdi_kind_type      kind_ff;
  vdi_kind_type      nxt_kind;
  logic [1:0]        ph_ff;
  logic [1:0]        nxt_ph;
  logic [3:0]        bit_ff;
  logic [3:0]        nxt_bit;
  logic [QTR_W-1:0]  qc_ff;
  logic [QTR_W-1:0]  nxt_qc;
  logic [BYTE_W-1:0] tx_ff;
  logic [BYTE_W-1:0] nxt_tx;
  logic [BYTE_W-1:0] sub_ff;
  logic [BYTE_W-1:0] nxt_sub;
  logic              last_ff;
  logic              nxt_last;
  logic              scl_oe_ff;
  logic              nxt_scl_oe;
  logic              sda_oe_ff;
  logic              nxt_sda_oe;
  logic              rdy_ff;
  logic              nxt_rdy;
  logic              drdy_ff;
  logic              nxt_drdy;
  logic              done_ff;
  logic              nxt_done;
  logic              nack_ff;
  logic              nxt_nack;
  logic              tick;

  // two flip-flops on the line levels
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 2'h3;
      sync2_ff <= 2'h3;
    end else begin
      sync1_ff <= {lnk.sda, lnk.scl};
      sync2_ff <= sync1_ff;
    end
  end

  assign tick = (qc_ff == QTR_LAST);

  always_comb begin
    nxt_st     = st_ff;
    nxt_kind   = kind_ff;
    nxt_ph     = ph_ff;
    nxt_bit    = bit_ff;
    nxt_qc     = tick ? '0 : qc_ff + QTR_ONE;
    nxt_tx     = tx_ff;
    nxt_sub    = sub_ff;
    nxt_last   = last_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_drdy   = 1'b0;
    nxt_done   = 1'b0;
    nxt_nack   = nack_ff;
    // clock held low by the device: wait for the line
    if (ph_ff == 2'h1 && !sync2_ff[0] && st_ff != M_IDLE) begin
      nxt_qc = '0;
    end
    case (st_ff)
      M_IDLE: begin
        nxt_scl_oe = 1'b0;
        nxt_sda_oe = 1'b0;
        nxt_qc     = '0;
        if (req_valid && rdy_ff) begin
          // start, then address with write bit
          nxt_sda_oe = 1'b1;
          nxt_tx     = {req_addr7, 1'b0};
          nxt_sub    = req_sub;
          nxt_kind   = K_ADDR;
          nxt_nack   = 1'b0;
          nxt_st     = M_START;
        end
      end
      M_START: begin
        if (tick) begin
          nxt_scl_oe = 1'b1;
          nxt_bit    = 4'h0;
          nxt_ph     = 2'h3;
          nxt_st     = M_XFER;
        end
      end
      M_XFER: begin
        if (tick) begin
          nxt_ph = ph_ff + 2'h1;
          case (ph_ff)
            2'h0: nxt_scl_oe = 1'b0;
            2'h2: begin
              nxt_scl_oe = 1'b1;
              nxt_bit    = bit_ff + BIT_ONE;
              if (bit_ff == BIT_FULL) begin
                nxt_nack = sync2_ff[1];
              end
            end
            2'h3: begin
              if (bit_ff < BIT_FULL) begin
                nxt_sda_oe = !tx_ff[3'(BYTE_W - 1) - bit_ff[2:0]];
              end else if (bit_ff == BIT_FULL) begin
                nxt_sda_oe = 1'b0;
              end else if (nack_ff || (kind_ff == K_DATA && last_ff)) begin
                nxt_sda_oe = 1'b1;
                nxt_ph     = 2'h0;
                nxt_st     = M_STOP;
              end else if (kind_ff == K_ADDR) begin
                nxt_tx     = sub_ff;
                nxt_kind   = K_SUB;
                nxt_bit    = 4'h0;
                nxt_sda_oe = !sub_ff[BYTE_W-1];
              end else if (dat_valid) begin
                nxt_tx     = dat_data;
                nxt_last   = dat_last;
                nxt_drdy   = 1'b1;
                nxt_kind   = K_DATA;
                nxt_bit    = 4'h0;
                nxt_sda_oe = !dat_data[BYTE_W-1];
              end else begin
                nxt_ph = ph_ff;
              end
            end
            default: ;
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          nxt_ph = ph_ff + 2'h1;
          case (ph_ff)
            2'h0: nxt_scl_oe = 1'b0;
            2'h2: nxt_sda_oe = 1'b0;
            2'h3: begin
              nxt_done = 1'b1;
              nxt_st   = M_IDLE;
            end
            default: ;
          endcase
        end
      end
      default: nxt_st = M_IDLE;
    endcase
    nxt_rdy = (nxt_st == M_IDLE);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff     <= M_IDLE;
      kind_ff   <= K_ADDR;
      ph_ff     <= 2'h0;
      bit_ff    <= 4'h0;
      qc_ff     <= '0;
      tx_ff     <= 8'h00;
      sub_ff    <= 8'h00;
      last_ff   <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      rdy_ff    <= 1'b0;
      drdy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      nack_ff   <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      kind_ff   <= nxt_kind;
      ph_ff     <= nxt_ph;
      bit_ff    <= nxt_bit;
      qc_ff     <= nxt_qc;
      tx_ff     <= nxt_tx;
      sub_ff    <= nxt_sub;
      last_ff   <= nxt_last;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      rdy_ff    <= nxt_rdy;
      drdy_ff   <= nxt_drdy;
      done_ff   <= nxt_done;
      nack_ff   <= nxt_nack;
    end
  end

  assign lnk.scl_hst_o  = 1'b0;
  assign lnk.scl_hst_oe = scl_oe_ff;
  assign lnk.sda_hst_o  = 1'b0;
  assign lnk.sda_hst_oe = sda_oe_ff;
  assign req_ready      = rdy_ff;
  assign dat_ready      = drdy_ff;
  assign done           = done_ff;
  assign nack           = nack_ff;
endmodule
`default_nettype wire

// ===== test/vdi_link_props.sv
// timing assertions on the two-wire link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module vdi_link_props (
  // clocks and reset
  input wire logic link_clk,
  input wire logic ref_clk,
  input wire logic rst,
  // device drivers and line levels
  input wire logic scl_dev_o,
  input wire logic scl_dev_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  import vdi_pkg::*;
  logic [10:0] st_ff;
  logic [9:0]  gap_ff;
  logic        scl_q_ff;

  // cycles the device has held the clock low so far
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      st_ff <= 11'h000;
    end else begin
      st_ff <= scl_dev_oe ? st_ff + 11'h001 : 11'h000;
    end
  end

  // system cycles since the last clock rise, saturating
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_ff   <= 10'h3ff;
      scl_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl;
      gap_ff   <= (scl && !scl_q_ff) ? 10'h001 : ((gap_ff == 10'h3ff) ? gap_ff : gap_ff + 10'h001);
    end
  end

  // device pulls the clock low only for a bounded hold
  a_hold_bounded: assert property (@(posedge link_clk) disable iff (rst)
    scl_dev_oe |-> !scl_dev_o && st_ff < 11'(STRETCH_CYC)) else $error("device held clock");
  a_clock_hold_low: assert property (@(posedge link_clk) disable iff (rst)
    $rose(scl_dev_oe) |-> !$past(scl)) else $error("device hold began with clock high");
  a_ack_scl_low: assert property (@(posedge link_clk) disable iff (rst)
    $changed(sda_dev_oe) |-> !scl) else $error("device data changed with clock high");
  a_ack_reach_high: assert property (@(posedge link_clk) disable iff (rst)
    $rose(sda_dev_oe) |-> ##[1:60] (scl && sda_dev_oe && !sda_dev_o))
    else $error("ack missed its clock");
  a_ack_end: assert property (@(posedge link_clk) disable iff (rst)
    $rose(scl) && sda_dev_oe |-> ##[1:60] !sda_dev_oe) else $error("ack not released");
  a_start_quiet: assert property (@(posedge link_clk) disable iff (rst)
    $fell(sda) && scl |=> !sda_dev_oe) else $error("device pulled data after start");
  a_hold_length: assert property (@(posedge link_clk) disable iff (rst)
    $fell(scl_dev_oe) |-> st_ff == 11'(STRETCH_CYC)) else $error("clock hold length wrong");
  a_bit_rate: assert property (@(posedge ref_clk) disable iff (rst)
    scl && !scl_q_ff |-> gap_ff >= 10'(BIT_PS / REF_CLK_PS)) else $error("bit rate too high");

  // main scenarios reached
  c_ack: cover property (@(posedge link_clk) disable iff (rst) $rose(sda_dev_oe));
  c_hold: cover property (@(posedge link_clk) disable iff (rst) $fell(scl_dev_oe));
  c_start: cover property (@(posedge link_clk) disable iff (rst) $fell(sda) && scl);
endmodule
`default_nettype wire

// ===== test/video_decoder_i2c_slave_port_test.sv
// self-checking bench: host and device ends across one link
`timescale 1ns/1ps
`default_nettype none
module video_decoder_i2c_slave_port_test;
  import vdi_pkg::*;
  logic        ref_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap = 1'b0;
  logic        vbit = 1'b0;
  logic        vbit_q = 1'b0;
  logic        pin_i, pin_o, pin_oe, wr_valid, strap_q, strap_done;
  logic [7:0]  wr_addr, wr_data;
  logic        req_valid = 1'b0;
  logic        dat_valid = 1'b0;
  logic        dat_last = 1'b0;
  logic [6:0]  req_addr7 = 7'h00;
  logic [7:0]  req_sub = 8'h00;
  logic [7:0]  dat_data = 8'h00;
  logic        req_ready, dat_ready, done, nack;
  int          n_errors = 0;
  int          samples_checked = 0;
  logic [15:0] exp_q[$];

  vdi_link_if lnk();

  // system clock, and link clock of unrelated phase
  always #2 ref_clk = ~ref_clk;
  initial begin
    #7.3;
    forever #32 link_clk = ~link_clk;
  end

  // shared pin: strap level until the device drives it
  assign pin_i = pin_oe ? pin_o : strap;

  vdi_slave_port vdi_slave_port_inst (
    .link_clk(link_clk), .rst(rst), .lnk(lnk), .video_output_bit7_pin_i(pin_i),
    .video_output_bit7_pin_o(pin_o), .video_output_bit7_pin_oe(pin_oe),
    .video_bit7_data(vbit), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .slave_address_select_strap(strap_q), .strap_done(strap_done));
  vdi_host_master vdi_host_master_inst (
    .ref_clk(ref_clk), .rst(rst), .lnk(lnk), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr7(req_addr7), .req_sub(req_sub), .dat_valid(dat_valid), .dat_ready(dat_ready),
    .dat_data(dat_data), .dat_last(dat_last), .done(done), .nack(nack));
  vdi_link_props vdi_link_props_inst (
    .link_clk(link_clk), .ref_clk(ref_clk), .rst(rst), .scl_dev_o(lnk.scl_dev_o),
    .scl_dev_oe(lnk.scl_dev_oe), .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe),
    .scl(lnk.scl), .sda(lnk.sda));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // wait for ready, data taken or done, bounded
  task automatic wait_on(input int sel);
    int k;
    for (k = 0; k < 40000; k++) begin
      @(posedge ref_clk);
      if ((sel == 0 && req_ready === 1'b1) || (sel == 1 && dat_ready === 1'b1) ||
          (sel == 2 && done === 1'b1))
        return;
    end
    n_errors++;
    $display("ERROR at %0t: wait %0d timed out", $time, sel);
  endtask

  // video bit follows its source; each written byte matches the model
  always @(posedge link_clk) begin
    if (strap_done === 1'b1)
      check(16'(pin_o), 16'(vbit_q));
    if (wr_valid === 1'b1)
      check({wr_addr, wr_data}, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx);
    vbit_q <= vbit;
    #1 vbit = 1'($urandom);
  end

  // reset with a given strap level, then check the captured address choice
  task automatic do_reset(input logic s);
    int k;
    strap = s;
    rst = 1'b1;
    repeat (10) @(posedge link_clk);
    #1 rst = 1'b0;
    for (k = 0; k < 20 && strap_done !== 1'b1; k++)
      @(posedge link_clk);
    #1;
    check(16'(strap_q), 16'(s));
    check(16'(pin_oe), 16'h0001);
  endtask

  // one write: address, subaddress, then n random data bytes, or no data bytes when bad
  task automatic wr(input logic [6:0] a7, input logic [7:0] sub, input int n, input logic bad);
    logic [7:0] d;
    int         i;
    @(posedge ref_clk);
    #1;
    req_valid = 1'b1;
    req_addr7 = a7;
    req_sub = sub;
    wait_on(0);
    #1 req_valid = 1'b0;
    for (i = 0; i < n && !bad; i++) begin
      d = 8'($urandom);
      dat_valid = 1'b1;
      dat_data = d;
      dat_last = (i == n - 1);
      exp_q.push_back({sub + 8'(i), d});
      wait_on(1);
      #1;
    end
    dat_valid = 1'b0;
    wait_on(2);
    @(posedge ref_clk);
    check(16'(nack), 16'(bad));
  endtask

  // main sequence
  initial begin
    void'($urandom(32'hfeea52e8));
    do_reset(1'b0);
    wr(7'h5c, 8'hff, 2, 1'b0);
    $display("test pointer wrap done");
    wr(7'h5d, 8'h10, 1, 1'b1);
    $display("test foreign address done");
    do_reset(1'b1);
    wr(7'h5d, 8'h8f, 2, 1'b0);
    $display("test second strap and hold boundary done");
    repeat (40) @(posedge link_clk);
    check(16'(exp_q.size()), 16'h0000);
    finish_test();
  end

  // watchdog against a hung link
  initial begin
    #390000;
    n_errors++;
    $display("ERROR at %0t: run timed out", $time);
    finish_test();
  end
endmodule
`default_nettype wire
